/* hw/imbms_top.sv */
// Purpose: Device side of an instrument bus talker/listener with status system.
// Assumes: Bus pins arrive synchronous to clk; bus_stb marks one accepted byte.
// Notes: Firmware parses command text and supplies responses and readings.
//
// Summary of operation
// - REN asserted puts device into remote
// - IFC aborts any transfer in progress
// - Device drives only SRQ as uniline
// - Bytes under ATN are bus commands
// - LLO locks out the front panel
// - DCL returns bus logic to idle
// - Addressed commands need own listen address
// - SDC clears only when listen addressed
// - GTL while addressed returns to local
// - GET while addressed starts data log
// - Serial poll returns status byte when talking
// - Star means common, question mark means query
// - Semicolons split; buffer holds 256 characters
// - Respond only when addressed to talk
// - Answer only the latest query
// - Binary readings are single precision floats
// - Two header bytes, four per reading, EOI last
// - Send exactly the requested reading count
// - Condition registers are live and read only
// - Event bits stick until read or cleared
// - Event AND enable ORed into summary bit
// - Enabled summary sets RQS and drives SRQ
// - Status byte summary bits do not latch
`timescale 1ns/1ns
module imbms_top
	import imbms_pkg::*;
(
	input  wire logic        clk,          // 25 MHz clock.
	input  wire logic        sys_rst,      // Synchronous reset, active high.
	input  wire logic        psel,         // APB select.
	input  wire logic        penable,      // APB enable.
	input  wire logic        pwrite,       // APB write.
	input  wire logic [7:0]  paddr,        // APB byte address.
	input  wire logic [31:0] pwdata,       // APB write data.
	output logic      [31:0] prdata,       // APB read data.
	output logic             pready,       // APB ready.
	output logic             pslverr,      // APB error on unmapped address.
	input  wire logic        bus_stb,      // One byte accepted from the bus.
	input  wire logic [7:0]  bus_dio,      // Bus data lines, true polarity.
	input  wire logic        bus_atn_n,    // ATN line level.
	input  wire logic        bus_eoi_n,    // EOI line level with bus_stb.
	input  wire logic        bus_ren_n,    // REN line level.
	input  wire logic        bus_ifc_n,    // IFC line level.
	input  wire logic        srq_i,        // SRQ line level.
	output logic             srq_o,        // SRQ drive value, always low.
	output logic             srq_oe,       // SRQ pulled low while high.
	output logic             talk_valid,   // Byte offered to the bus.
	output logic      [7:0]  talk_byte,    // Byte to send.
	output logic             talk_eoi,     // EOI with this byte.
	input  wire logic        talk_ack,     // Offered byte taken by the bus.
	output logic             remote,       // Remote state.
	output logic             lockout,      // Front panel locked out.
	output logic             dlog_trigger, // One-cycle data log start.
	input  wire logic [7:0]  std_evt,      // Standard event pulses.
	input  wire logic [7:0]  op_cond       // Live operation conditions.
);
	logic [4:0]  addr_q;
	logic        listen_q, talk_q, spoll_q, sp_sent_q, ren_q;
	logic        remote_q, lockout_q, trig_q, srq_q;
	logic        tv_q, teoi_q;
	logic [7:0]  tbyte_q;
	logic [7:0]  rx_mem_q [RX_DEPTH];
	logic [7:0]  rx_wp_q, rx_rp_q;
	logic [8:0]  rx_cnt_q;
	logic [8:0]  rsp_mem_q [RSP_DEPTH];
	logic [3:0]  rsp_wp_q, rsp_rp_q;
	logic [4:0]  rsp_cnt_q;
	logic        seg_start_q, seg_com_q, seg_qry_q, last_com_q, last_qry_q;
	imbms_bin_e  bin_st_q;
	logic [15:0] bin_cnt_q;
	logic [1:0]  bin_idx_q;
	logic [31:0] bin_word_q;
	logic        bin_full_q;
	logic [7:0]  esr_q, ese_q, oevt_q, oen_q, sre_q, opc_prev_q;
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q;

	////////////////////////////////////////////////////////////////////////////
	logic        ifc, cmd, din, dev_clr, seg_end, qry_end;
	logic        wr, rd, ld_sp, ld_bin, ld_resp, bin_last;
	logic [6:0]  c;
	logic [7:0]  sum, bin_byte, stb_val;
	logic        rqs_d;

	assign ifc      = !bus_ifc_n;
	assign c        = bus_dio[6:0];
	assign cmd      = bus_stb && !bus_atn_n;
	assign din      = bus_stb && bus_atn_n && listen_q;
	assign dev_clr  = cmd && (c == CMD_DCL || (c == CMD_SDC && listen_q));
	assign seg_end  = din && (bus_dio == CH_SEMI || bus_dio == CH_LF || !bus_eoi_n);
	assign qry_end  = seg_end && (seg_qry_q || bus_dio == CH_QM);
	assign wr       = psel && penable && pready_q && pwrite;
	assign rd       = psel && penable && pready_q && !pwrite;
	assign ld_sp    = !tv_q && talk_q && spoll_q && !sp_sent_q;
	assign ld_bin   = !tv_q && talk_q && !ld_sp && bin_st_q != B_IDLE
			&& (bin_st_q != B_DATA || bin_full_q);
	assign ld_resp  = !tv_q && talk_q && !ld_sp && !ld_bin && rsp_cnt_q != 5'h00;
	assign bin_last = bin_st_q == B_DATA && bin_cnt_q == 16'h0001 && bin_idx_q == 2'h3;
	assign bin_byte = bin_st_q == B_HDR0 ? BIN_HDR0 : bin_st_q == B_HDR1 ? BIN_HDR1
			: bin_word_q[{~bin_idx_q, 3'b000} +: 8];
	assign sum      = {|(oevt_q & oen_q), 1'b0, |(esr_q & ese_q), rsp_cnt_q != 5'h00, 4'h0};
	assign rqs_d    = |(sum & sre_q & STB_MASK);
	assign stb_val  = sum | {1'b0, srq_q, 6'h00};

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (sys_rst || ifc) begin
			listen_q <= 1'b0;
			talk_q   <= 1'b0;
		end else if (cmd) begin
			if (c == {2'b01, addr_q}) begin
				listen_q <= 1'b1;
				talk_q   <= 1'b0;
			end else if (c == {2'b10, addr_q}) begin
				talk_q   <= 1'b1;
				listen_q <= 1'b0;
			end else if (c == CMD_UNL) begin
				listen_q <= 1'b0;
			end else if (c == CMD_UNT || c[6:5] == 2'b10) begin
				talk_q   <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ren_q     <= 1'b0;
			remote_q  <= 1'b0;
			lockout_q <= 1'b0;
		end else begin
			ren_q <= !bus_ren_n;
			if (bus_ren_n) begin
				remote_q  <= 1'b0;
				lockout_q <= 1'b0;
			end else if (!ren_q) begin
				remote_q <= 1'b1;
			end else if (cmd && c == CMD_GTL && listen_q) begin
				remote_q <= 1'b0;
			end else if (cmd && c == {2'b01, addr_q}) begin
				remote_q <= 1'b1;
			end
			if (!bus_ren_n && cmd && c == CMD_LLO) begin
				lockout_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			trig_q <= 1'b0;
		end else begin
			trig_q <= cmd && c == CMD_GET && listen_q;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || ifc) begin
			spoll_q   <= 1'b0;
			sp_sent_q <= 1'b0;
		end else if (cmd && c == CMD_SPE) begin
			spoll_q   <= 1'b1;
			sp_sent_q <= 1'b0;
		end else if (cmd && c == CMD_SPD) begin
			spoll_q   <= 1'b0;
		end else if (ld_sp) begin
			sp_sent_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (sys_rst || ifc || dev_clr) begin
			tv_q    <= 1'b0;
			teoi_q  <= 1'b0;
			tbyte_q <= 8'h00;
		end else if (tv_q) begin
			if (talk_ack) begin
				tv_q <= 1'b0;
			end
		end else if (ld_sp) begin
			tv_q    <= 1'b1;
			tbyte_q <= stb_val;
			teoi_q  <= 1'b0;
		end else if (ld_bin) begin
			tv_q    <= 1'b1;
			tbyte_q <= bin_byte;
			teoi_q  <= bin_last;
		end else if (ld_resp) begin
			tv_q    <= 1'b1;
			tbyte_q <= rsp_mem_q[rsp_rp_q][7:0];
			teoi_q  <= rsp_mem_q[rsp_rp_q][8];
		end
	end

	// Received text is held for firmware; one slot beyond the longest string.
	always_ff @(posedge clk) begin
		if (sys_rst || dev_clr) begin
			rx_wp_q  <= 8'h00;
			rx_rp_q  <= 8'h00;
			rx_cnt_q <= 9'h000;
		end else begin
			if (din && rx_cnt_q != 9'(RX_DEPTH)) begin
				rx_mem_q[rx_wp_q] <= bus_dio;
				rx_wp_q           <= rx_wp_q + 8'h01;
			end
			if (rd && paddr == ADR_RXD && rx_cnt_q != 9'h000) begin
				rx_rp_q <= rx_rp_q + 8'h01;
			end
			rx_cnt_q <= rx_cnt_q + 9'(din && rx_cnt_q != 9'(RX_DEPTH))
				- 9'(rd && paddr == ADR_RXD && rx_cnt_q != 9'h000);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst || dev_clr) begin
			seg_start_q <= 1'b1;
			seg_com_q   <= 1'b0;
			seg_qry_q   <= 1'b0;
			last_com_q  <= 1'b0;
			last_qry_q  <= 1'b0;
		end else if (seg_end) begin
			last_com_q  <= seg_com_q || (seg_start_q && bus_dio == CH_STAR);
			last_qry_q  <= qry_end;
			seg_start_q <= 1'b1;
			seg_com_q   <= 1'b0;
			seg_qry_q   <= 1'b0;
		end else if (din) begin
			seg_start_q <= 1'b0;
			if (seg_start_q && bus_dio == CH_STAR) begin
				seg_com_q <= 1'b1;
			end
			if (bus_dio == CH_QM) begin
				seg_qry_q <= 1'b1;
			end
		end
	end

	// A fresh query drops any answer still queued for an older one.
	always_ff @(posedge clk) begin
		if (sys_rst || ifc || dev_clr || qry_end) begin
			rsp_wp_q  <= 4'h0;
			rsp_rp_q  <= 4'h0;
			rsp_cnt_q <= 5'h00;
		end else begin
			if (wr && paddr == ADR_RESP && rsp_cnt_q != 5'(RSP_DEPTH)) begin
				rsp_mem_q[rsp_wp_q] <= pwdata[8:0];
				rsp_wp_q            <= rsp_wp_q + 4'h1;
			end
			if (ld_resp) begin
				rsp_rp_q <= rsp_rp_q + 4'h1;
			end
			rsp_cnt_q <= rsp_cnt_q + 5'(wr && paddr == ADR_RESP && rsp_cnt_q != 5'(RSP_DEPTH))
				- 5'(ld_resp);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (sys_rst || ifc || dev_clr) begin
			bin_st_q   <= B_IDLE;
			bin_cnt_q  <= 16'h0000;
			bin_idx_q  <= 2'h0;
			bin_full_q <= 1'b0;
			bin_word_q <= 32'h0000_0000;
		end else begin
			if (wr && paddr == ADR_BDAT && !bin_full_q) begin
				bin_word_q <= pwdata;
				bin_full_q <= 1'b1;
			end
			case (bin_st_q)
				B_IDLE: begin
					if (wr && paddr == ADR_BCNT && pwdata[15:0] != 16'h0000) begin
						bin_cnt_q <= pwdata[15:0];
						bin_st_q  <= B_HDR0;
					end
				end
				B_HDR0: begin
					if (ld_bin) begin
						bin_st_q <= B_HDR1;
					end
				end
				B_HDR1: begin
					if (ld_bin) begin
						bin_st_q  <= B_DATA;
						bin_idx_q <= 2'h0;
					end
				end
				default: begin
					if (ld_bin) begin
						bin_idx_q <= bin_idx_q + 2'h1;
						if (bin_idx_q == 2'h3) begin
							bin_full_q <= 1'b0;
							bin_cnt_q  <= bin_cnt_q - 16'h0001;
							if (bin_cnt_q == 16'h0001) begin
								bin_st_q <= B_IDLE;
							end
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// A read clears only the bits it reported, so a new event is never lost.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			esr_q      <= 8'h00;
			oevt_q     <= 8'h00;
			opc_prev_q <= 8'h00;
		end else begin
			opc_prev_q <= op_cond;
			if (wr && paddr == ADR_CLS) begin
				esr_q  <= std_evt;
				oevt_q <= op_cond & ~opc_prev_q;
			end else begin
				esr_q  <= (esr_q & ~(rd && paddr == ADR_ESR ? prdata_q[7:0] : 8'h00))
					| std_evt;
				oevt_q <= (oevt_q & ~(rd && paddr == ADR_OEVT ? prdata_q[7:0] : 8'h00))
					| (op_cond & ~opc_prev_q);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			addr_q <= RST_ADDR;
			ese_q  <= 8'h00;
			oen_q  <= 8'h00;
			sre_q  <= 8'h00;
		end else if (wr) begin
			if (paddr == ADR_CFG) begin
				addr_q <= pwdata[4:0];
			end else if (paddr == ADR_ESE) begin
				ese_q <= pwdata[7:0];
			end else if (paddr == ADR_OEN) begin
				oen_q <= pwdata[7:0];
			end else if (paddr == ADR_SRE) begin
				sre_q <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			srq_q <= 1'b0;
		end else begin
			srq_q <= rqs_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= psel && !penable;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			if (psel && !penable) begin
				if (paddr == ADR_CFG) begin
					prdata_q <= {27'h0, addr_q};
				end else if (paddr == ADR_STAT) begin
					prdata_q <= {8'h00, rx_cnt_q[7:0], 6'h00, last_qry_q, last_com_q,
						srq_i, bin_full_q, bin_st_q != B_IDLE, spoll_q, talk_q, listen_q,
						lockout_q, remote_q};
				end else if (paddr == ADR_RXD) begin
					prdata_q <= {23'h0, rx_cnt_q != 9'h000, rx_mem_q[rx_rp_q]};
				end else if (paddr == ADR_ESR) begin
					prdata_q <= {24'h0, esr_q};
				end else if (paddr == ADR_ESE) begin
					prdata_q <= {24'h0, ese_q};
				end else if (paddr == ADR_OCOND) begin
					prdata_q <= {24'h0, op_cond};
				end else if (paddr == ADR_OEVT) begin
					prdata_q <= {24'h0, oevt_q};
				end else if (paddr == ADR_OEN) begin
					prdata_q <= {24'h0, oen_q};
				end else if (paddr == ADR_SRE) begin
					prdata_q <= {24'h0, sre_q};
				end else if (paddr == ADR_STB) begin
					prdata_q <= {24'h0, stb_val};
				end else if (paddr != ADR_RESP && paddr != ADR_BCNT && paddr != ADR_BDAT
						&& paddr != ADR_CLS) begin
					pslverr_q <= 1'b1;
				end
			end
		end
	end

	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign srq_o        = 1'b0;
	assign srq_oe       = srq_q;
	assign talk_valid   = tv_q;
	assign talk_byte    = tbyte_q;
	assign talk_eoi     = teoi_q;
	assign remote       = remote_q;
	assign lockout      = lockout_q;
	assign dlog_trigger = trig_q;

	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_ren; !bus_ren_n && !ren_q |=> remote_q; endproperty
	a_ren: assert property (p_ren) else $error("REN did not enter remote");
	property p_ifc; ifc |=> !tv_q && !listen_q && !talk_q; endproperty
	a_ifc: assert property (p_ifc) else $error("IFC did not abort");
	property p_srq; rqs_d |=> srq_oe ##0 stb_val[6]; endproperty
	a_srq: assert property (p_srq) else $error("SRQ not raised");
	property p_llo; !bus_ren_n && cmd && c == CMD_LLO |=> lockout_q; endproperty
	a_llo: assert property (p_llo) else $error("LLO ignored");
	property p_dcl; cmd && c == CMD_DCL |=> rx_cnt_q == 9'h000 && bin_st_q == B_IDLE && !tv_q; endproperty
	a_dcl: assert property (p_dcl) else $error("DCL left activity");
	property p_get; cmd && c == CMD_GET |=> dlog_trigger == $past(listen_q); endproperty
	a_get: assert property (p_get) else $error("GET addressing wrong");
	property p_talk; $rose(tv_q) |-> $past(talk_q); endproperty
	a_talk: assert property (p_talk) else $error("Sent while not talker");
	property p_eoi;
		ld_bin && bin_last && !ifc && !dev_clr |=> talk_eoi && talk_valid && bin_st_q == B_IDLE;
	endproperty
	a_eoi: assert property (p_eoi) else $error("EOI not on last byte");
	property p_esr;
		std_evt[0] |=> esr_q[0] ##1 (esr_q[0] || $past(rd && paddr == ADR_ESR || wr && paddr == ADR_CLS));
	endproperty
	a_esr: assert property (p_esr) else $error("Event bit not held");
endmodule

/* hw/imbms_pkg.sv */
// Purpose: Constants for the instrument bus message and status block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Bus command codes are compared on the low seven data lines.
package imbms_pkg;
	localparam logic [7:0] ADR_CFG   = 8'h00;
	localparam logic [7:0] ADR_STAT  = 8'h04;
	localparam logic [7:0] ADR_RXD   = 8'h08;
	localparam logic [7:0] ADR_RESP  = 8'h0C;
	localparam logic [7:0] ADR_BCNT  = 8'h10;
	localparam logic [7:0] ADR_BDAT  = 8'h14;
	localparam logic [7:0] ADR_ESR   = 8'h18;
	localparam logic [7:0] ADR_ESE   = 8'h1C;
	localparam logic [7:0] ADR_OCOND = 8'h20;
	localparam logic [7:0] ADR_OEVT  = 8'h24;
	localparam logic [7:0] ADR_OEN   = 8'h28;
	localparam logic [7:0] ADR_SRE   = 8'h2C;
	localparam logic [7:0] ADR_STB   = 8'h30;
	localparam logic [7:0] ADR_CLS   = 8'h34;
	localparam logic [4:0] RST_ADDR  = 5'h0C;
	localparam logic [6:0] CMD_GTL   = 7'h01;
	localparam logic [6:0] CMD_SDC   = 7'h04;
	localparam logic [6:0] CMD_GET   = 7'h08;
	localparam logic [6:0] CMD_LLO   = 7'h11;
	localparam logic [6:0] CMD_DCL   = 7'h14;
	localparam logic [6:0] CMD_SPE   = 7'h18;
	localparam logic [6:0] CMD_SPD   = 7'h19;
	localparam logic [6:0] CMD_UNL   = 7'h3F;
	localparam logic [6:0] CMD_UNT   = 7'h5F;
	localparam logic [7:0] CH_STAR   = 8'h2A;
	localparam logic [7:0] CH_QM     = 8'h3F;
	localparam logic [7:0] CH_SEMI   = 8'h3B;
	localparam logic [7:0] CH_LF     = 8'h0A;
	localparam logic [7:0] BIN_HDR0  = 8'h23;
	localparam logic [7:0] BIN_HDR1  = 8'h30;
	localparam int         RX_DEPTH  = 256;
	localparam int         RSP_DEPTH = 16;
	localparam logic [7:0] STB_MASK  = 8'hBF;
	typedef enum logic [1:0] {B_IDLE, B_HDR0, B_HDR1, B_DATA} imbms_bin_e;
endpackage

/* tb/imbms_ctrl_model.sv */
// Purpose: Bus controller model for the instrument bus side.
// Assumes: ATN, EOI, REN, IFC and SRQ have pull-ups.
// Notes: Released data lines show the inverse of the last byte.
`timescale 1ns/1ns
module imbms_ctrl_model
	import imbms_pkg::*;
(
	input  wire logic       clk,        // Clock.
	output logic            bus_stb,    // Byte strobe.
	output logic      [7:0] bus_dio,    // Data lines.
	output logic            bus_atn_n,  // ATN level.
	output logic            bus_eoi_n,  // EOI level.
	output logic            bus_ren_n,  // REN level.
	output logic            bus_ifc_n,  // IFC level.
	output logic            srq_i,      // Wired SRQ level.
	input  wire logic       srq_o,      // SRQ drive value.
	input  wire logic       srq_oe,     // SRQ drive enable.
	input  wire logic       talk_valid, // Byte offered.
	input  wire logic [7:0] talk_byte,  // Offered byte.
	input  wire logic       talk_eoi,   // EOI with byte.
	output logic            talk_ack    // Byte taken.
);
	assign srq_i = srq_oe ? srq_o : 1'b1;
	initial begin
		bus_stb = 1'b0;
		bus_dio = 8'h00;
		bus_atn_n = 1'b1;
		bus_eoi_n = 1'b1;
		bus_ren_n = 1'b1;
		bus_ifc_n = 1'b1;
		talk_ack = 1'b0;
	end
	////////////////////////////////////////
	task automatic put(input logic [7:0] b, input logic cmd, input logic last);
		@(posedge clk);
		bus_stb <= 1'b1;
		bus_dio <= b;
		bus_atn_n <= ~cmd;
		bus_eoi_n <= ~last;
		@(posedge clk);
		bus_stb <= 1'b0;
		bus_dio <= ~b;
		bus_atn_n <= 1'b1;
		bus_eoi_n <= 1'b1;
	endtask
	task automatic msg(input string s);
		for (int i = 0; i < s.len() && i < 255; i++) begin
			put(s[i], 1'b0, 1'b0);
		end
		put(CH_LF, 1'b0, 1'b1);
	endtask
	task automatic get(output logic [8:0] v, output logic ok);
		ok = 1'b0;
		v = 9'h000;
		for (int n = 0; n < 300 && !ok; n++) begin
			@(negedge clk);
			ok = (talk_valid === 1'b1);
		end
		if (ok) begin
			v = {talk_eoi, talk_byte};
			@(posedge clk);
			talk_ack <= 1'b1;
			@(posedge clk);
			talk_ack <= 1'b0;
		end
	endtask
	task automatic lines(input logic ren, input logic ifc);
		@(posedge clk);
		bus_ren_n <= ~ren;
		bus_ifc_n <= ~ifc;
	endtask
endmodule

/* tb/tb_imbms_top.sv */
// Purpose: Self-checking bench for the instrument bus block.
// Assumes: The slave may hold pready low; the master waits for it.
// Notes: Random words come from an LFSR seeded with 32'hcafe.
`timescale 1ns/1ns
module tb_imbms_top import imbms_pkg::*;;
	localparam logic [7:0] LA = {3'b001, RST_ADDR};
	localparam logic [7:0] TA = {3'b010, RST_ADDR};
	logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, rerr;
	logic [7:0]  paddr, bus_dio, talk_byte, std_evt, op_cond;
	logic [31:0] pwdata, prdata, rdata, seed, e;
	logic        bus_stb, bus_atn_n, bus_eoi_n, bus_ren_n, bus_ifc_n, srq_i, srq_o, srq_oe;
	logic        talk_valid, talk_eoi, talk_ack, remote, lockout, dlog_trigger;
	int          errors, compares, trig_n, cyc;
	imbms_top i_imbms_top (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .bus_stb, .bus_dio, .bus_atn_n, .bus_eoi_n, .bus_ren_n, .bus_ifc_n,
		.srq_i, .srq_o, .srq_oe, .talk_valid, .talk_byte, .talk_eoi, .talk_ack, .remote,
		.lockout, .dlog_trigger, .std_evt, .op_cond);
	imbms_ctrl_model i_imbms_ctrl_model (.clk, .bus_stb, .bus_dio, .bus_atn_n, .bus_eoi_n,
		.bus_ren_n, .bus_ifc_n, .srq_i, .srq_o, .srq_oe, .talk_valid, .talk_byte, .talk_eoi,
		.talk_ack);
	initial clk = 1'b0;
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (dlog_trigger === 1'b1) trig_n++;
		if (cyc > 60000) begin
			errors++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
	endfunction
	function automatic logic [31:0] stb_exp(input logic [7:0] esr, ese, sre);
		logic [7:0] s;
		s = {2'b00, |(esr & ese), 5'b00000};
		s[6] = |(s & sre & STB_MASK);
		return {24'h00_0000, s};
	endfunction
	task automatic tally_and_finish();
		if (errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic rdy;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		rdy = 1'b0;
		for (int n = 0; n < 20 && !rdy; n++) begin
			@(posedge clk);
			rdy = (pready === 1'b1);
		end
		if (!rdy) begin
			errors++;
			tally_and_finish();
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rdata & m, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic cmd(input logic [7:0] b);
		i_imbms_ctrl_model.put(b, 1'b1, 1'b0);
	endtask
	task automatic rx(input logic [8:0] exp);
		logic [8:0] v;
		logic       ok;
		i_imbms_ctrl_model.get(v, ok);
		chk({22'h00_0000, ok, v}, {22'h00_0000, 1'b1, exp});
		if (!ok) tally_and_finish();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		std_evt = 8'h00;
		op_cond = 8'h00;
		seed = 32'hcafe;
		tick(2);
		sys_rst <= 1'b0;
		rdm(ADR_CFG, 32'hFFFF_FFFF, {27'h000_0000, RST_ADDR});
		apb(1'b0, 8'h3C, 32'h0000_0000);
		chk({31'h0, rerr}, 32'h1);
		i_imbms_ctrl_model.lines(1'b1, 1'b0);
		tick(2);
		chk({31'h0, remote}, 32'h1);
		cmd({1'b0, CMD_LLO});
		tick(2);
		chk({31'h0, lockout}, 32'h1);
		cmd({1'b0, CMD_GET});
		tick(3);
		chk(trig_n, 0);
		cmd(LA);
		cmd({1'b0, CMD_GET});
		tick(3);
		chk(trig_n, 1);
		cmd({1'b0, CMD_GTL});
		tick(2);
		chk({31'h0, remote}, 32'h0);
		i_imbms_ctrl_model.msg("*IDN?");
		rdm(ADR_STAT, 32'h00FF_0300, 32'h0006_0300);
		i_imbms_ctrl_model.msg("RDG 1");
		rdm(ADR_STAT, 32'h0000_0300, 32'h0);
		rdm(ADR_RXD, 32'hFFFF_FFFF, 32'h0000_012A);
		wr(ADR_RESP, 32'h0000_0041);
		tick(8);
		chk({31'h0, talk_valid}, 32'h0);
		i_imbms_ctrl_model.msg("Q?");
		wr(ADR_RESP, 32'h0000_0142);
		cmd(TA);
		rx(9'h142);
		wr(ADR_ESE, 32'h1);
		wr(ADR_SRE, 32'h20);
		repeat (2) begin
			@(posedge clk);
			std_evt <= 8'h01;
			@(posedge clk);
			std_evt <= 8'h00;
		end
		tick(3);
		chk({30'h0, srq_oe, srq_o}, 32'h2);
		e = stb_exp(8'h01, 8'h01, 8'h20);
		rdm(ADR_STB, 32'hFFFF_FFFF, e);
		cmd({1'b0, CMD_SPE});
		cmd(TA);
		rx({1'b0, e[7:0]});
		cmd({1'b0, CMD_SPD});
		rdm(ADR_ESR, 32'hFFFF_FFFF, 32'h1);
		rdm(ADR_ESR, 32'hFFFF_FFFF, 32'h0);
		rdm(ADR_STB, 32'hFFFF_FFFF, stb_exp(8'h00, 8'h01, 8'h20));
		tick(2);
		chk({31'h0, srq_oe}, 32'h0);
		for (int k = 0; k < 4; k++) begin
			seed = lfsr(seed);
			@(posedge clk);
			op_cond <= seed[7:0];
			tick(2);
			rdm(ADR_OCOND, 32'hFFFF_FFFF, {24'h00_0000, seed[7:0]});
		end
		wr(ADR_CLS, 32'h0000_0000);
		op_cond <= 8'h00;
		tick(2);
		op_cond <= 8'h5A;
		tick(2);
		wr(ADR_OEN, 32'h0000_0002);
		rdm(ADR_STB, 32'h0000_0080, 32'h0000_0080);
		rdm(ADR_OEVT, 32'hFFFF_FFFF, 32'h0000_005A);
		rdm(ADR_OEVT, 32'hFFFF_FFFF, 32'h0000_0000);
		rdm(ADR_STB, 32'h0000_0080, 32'h0000_0000);
		wr(ADR_BCNT, 32'h2);
		rx({1'b0, BIN_HDR0});
		rx({1'b0, BIN_HDR1});
		for (int k = 0; k < 2; k++) begin
			seed = lfsr(seed);
			wr(ADR_BDAT, seed);
			for (int j = 3; j >= 0; j--) begin
				rx({k == 1 && j == 0, seed[8*j +: 8]});
			end
		end
		tick(6);
		chk({31'h0, talk_valid}, 32'h0);
		wr(ADR_BCNT, 32'h3);
		rx({1'b0, BIN_HDR0});
		cmd({1'b0, CMD_DCL});
		tick(2);
		chk({31'h0, talk_valid}, 32'h0);
		rdm(ADR_STAT, 32'h60, 32'h0);
		cmd(TA);
		wr(ADR_BCNT, 32'h1);
		cmd({1'b0, CMD_SDC});
		rdm(ADR_STAT, 32'h20, 32'h20);
		cmd(LA);
		cmd({1'b0, CMD_SDC});
		rdm(ADR_STAT, 32'h20, 32'h0);
		cmd(TA);
		wr(ADR_RESP, 32'h0000_015A);
		tick(4);
		chk({31'h0, talk_valid}, 32'h1);
		i_imbms_ctrl_model.lines(1'b1, 1'b1);
		i_imbms_ctrl_model.lines(1'b1, 1'b0);
		tick(2);
		chk({31'h0, talk_valid}, 32'h0);
		tally_and_finish();
	end
endmodule
